// >>> common/cildt_pkg.sv
/*
  constants and types for the camera i/o line, input filter and timer block.
  assumes a single 20 MHz device clock; times are counted in microsecond ticks
  made from that clock, except the 0.5 us filter default, which is counted in cycles.
*/
package cildt_pkg;

  // clock rate and the one-microsecond tick derived from it
  localparam int CLK_HZ          = 20_000_000;
  localparam int TICK_NS         = 1000;
  localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int HALF_US_CYC     = CYC_PER_US / 2;

  // programmable ranges in microseconds
  localparam int FILT_MAX_US     = 1_000_000;
  localparam int TIMER_MAX_US    = 60_000_000;
  localparam int DUR_MIN_US      = 1;
  localparam int FILT_W          = 20;
  localparam int TIME_W          = 26;

  // reset defaults; the filter default of 0.5 us is held in cycles
  localparam logic [FILT_W-1:0] FILT_DEF_US   = 20'h00000;
  localparam logic [TIME_W-1:0] DUR_DEF_US    = 26'h0000001;
  localparam logic [TIME_W-1:0] DELAY_DEF_US  = 26'h0000000;

  // line selector codes
  localparam logic LINE_IN  = 1'b0;
  localparam logic LINE_OUT = 1'b1;

  typedef enum logic [2:0]
  {
    SRC_OFF,
    SRC_EXPOSURE,
    SRC_READOUT,
    SRC_SOFTWARE,
    SRC_TIMER
  } cildt_src_t;

  typedef enum logic [1:0]
  {
    TRG_NONE,
    TRG_EXPOSURE,
    TRG_READOUT,
    TRG_INPUT
  } cildt_trg_t;

  typedef enum logic [1:0]
  {
    trig_on_rise,
    trig_on_fall,
    gate_while_high,
    gate_while_low
  } cildt_cond_t;

endpackage

// >>> common/cildt_tick_if.sv
/*
  carries the microsecond tick and the filtered input between the modules.
  assumes all ends share ref_clk_i.
*/
`timescale 1ns/10ps
interface cildt_tick_if;
  logic us_tick;
  logic filt_level;

  modport src
  (
    output us_tick,
    output filt_level
  );
  modport dst
  (
    input  us_tick,
    input  filt_level
  );
endinterface

// >>> rtl/cildt_filter.sv
/*
  input synchroniser, microsecond tick divider and input filter.
  assumes the input pin is asynchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module cildt_filter
  import cildt_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // raw line and setting
  input  wire logic              input_line_a_i,
  input  wire logic [FILT_W-1:0] filt_us_i,
  // towards the main block
  cildt_tick_if.src              tk
);
  import cildt_pkg::*;

  logic [2:0]        sync_r, sync_nxt;
  logic [4:0]        div_r, div_nxt;
  logic              tick_r, tick_nxt;
  logic              lvl_r, lvl_nxt;
  logic [FILT_W:0]   cnt_r, cnt_nxt;
  logic [FILT_W:0]   need;
  logic              stable;

  // second and third stage must agree before the filter looks at it
  assign stable = (sync_r[1] == sync_r[2]);
  // half a microsecond when zero is programmed, else whole microseconds;
  // one extra tick covers the free-running tick phase, so a level is
  // only taken after at least the full programmed time
  assign need = (filt_us_i == '0) ? (FILT_W+1)'(HALF_US_CYC)
                                  : {1'b0, filt_us_i} + (FILT_W+1)'(1);

  always_comb
  begin
    sync_nxt = {sync_r[1:0], input_line_a_i};
    tick_nxt = 1'b0;
    div_nxt  = div_r + 5'h01;
    if (div_r == 5'(CYC_PER_US - 1))
    begin
      div_nxt  = 5'h00;
      tick_nxt = 1'b1;
    end
    lvl_nxt = lvl_r;
    cnt_nxt = cnt_r;
    // restart the count on any change or on a level equal to current
    if (!stable || sync_r[2] == lvl_r)
      cnt_nxt = '0;
    else
    begin
      // count cycles for the half-us default, us ticks otherwise
      if (filt_us_i == '0 || tick_r)
        cnt_nxt = cnt_r + (FILT_W+1)'(1);
      if (cnt_nxt >= need)
      begin
        lvl_nxt = sync_r[2];
        cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_r <= 3'h0;
      div_r  <= 5'h00;
      tick_r <= 1'b0;
      lvl_r  <= 1'b0;
      cnt_r  <= '0;
    end
    else
    begin
      sync_r <= sync_nxt;
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
      lvl_r  <= lvl_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign tk.us_tick    = tick_r;
  assign tk.filt_level = lvl_r;
endmodule

// >>> rtl/cildt_timer.sv
/*
  programmable delay and pulse timer with edge or level activation.
  assumes the trigger source is already synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module cildt_timer
  import cildt_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // settings
  input  wire logic              restart_i,
  input  wire logic              enable_i,
  input  wire cildt_cond_t       cond_i,
  input  wire logic [TIME_W-1:0] delay_us_i,
  input  wire logic [TIME_W-1:0] dur_us_i,
  input  wire logic              src_i,
  // tick and result
  cildt_tick_if.dst              tk,
  output logic                   pulse_o
);
  import cildt_pkg::*;

  typedef enum {T_IDLE, T_DELAY, T_ACTIVE} cildt_tst_t;

  cildt_tst_t        st_r, st_nxt;
  logic [TIME_W-1:0] cnt_r, cnt_nxt;
  logic              prev_r, prev_nxt;
  logic              pulse_r, pulse_nxt;
  logic              fire, level_mode, level_on;

  assign level_mode = (cond_i == gate_while_high) ||
                      (cond_i == gate_while_low);
  assign level_on   = (cond_i == gate_while_high) ? src_i : !src_i;
  always_comb
  begin
    case (cond_i)
      trig_on_rise: fire = src_i && !prev_r;
      trig_on_fall: fire = !src_i && prev_r;
      default:      fire = level_on;
    endcase
  end

  always_comb
  begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    prev_nxt  = src_i;
    pulse_nxt = 1'b0;
    case (st_r)
      T_IDLE:
        if (enable_i && fire)
        begin
          st_nxt  = T_DELAY;
          cnt_nxt = '0;
        end
      T_DELAY:
        if (level_mode && !level_on)
          st_nxt = T_IDLE;
        else if (tk.us_tick)
        begin
          // phases start on a tick so the pulse is whole microseconds;
          // the cost is up to one extra microsecond of delay, never less
          if (cnt_r >= delay_us_i)
          begin
            st_nxt    = T_ACTIVE;
            cnt_nxt   = '0;
            pulse_nxt = 1'b1;
          end
          else
            cnt_nxt = cnt_r + TIME_W'(1);
        end
      T_ACTIVE:
      begin
        pulse_nxt = 1'b1;
        if (level_mode)
        begin
          if (!level_on)
          begin
            st_nxt    = T_IDLE;
            pulse_nxt = 1'b0;
          end
        end
        else
        begin
          if (tk.us_tick)
            cnt_nxt = cnt_r + TIME_W'(1);
          // zero width is clamped to the one-microsecond minimum
          if (cnt_nxt >= dur_us_i && cnt_nxt >= TIME_W'(DUR_MIN_US))
          begin
            st_nxt    = T_IDLE;
            pulse_nxt = 1'b0;
          end
        end
      end
      default: st_nxt = T_IDLE;
    endcase
    if (restart_i || !enable_i)
    begin
      st_nxt    = T_IDLE;
      cnt_nxt   = '0;
      pulse_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r    <= T_IDLE;
      cnt_r   <= '0;
      prev_r  <= 1'b0;
      pulse_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      prev_r  <= prev_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse_o = pulse_r;
endmodule

// >>> rtl/cildt_top.sv
/*
  digital i/o block of the camera: filtered trigger input, output line
  source selection with inversion, and the programmable timer.
  assumes exposure and readout status come from logic on ref_clk_i and
  that the settings are held steady by the control processor.
*/
`timescale 1ns/10ps
module cildt_top
  import cildt_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // line selection and settings
  input  wire logic              io_line_select_i,
  input  wire logic              output_polarity_invert_i,
  input  wire cildt_src_t        output_drive_source_i,
  input  wire logic              software_bit_value_i,
  input  wire logic [FILT_W-1:0] input_filter_time_i,
  // timer settings
  input  wire logic [TIME_W-1:0] timer_start_delay_i,
  input  wire logic [TIME_W-1:0] timer_pulse_width_i,
  input  wire logic              timer_restart_cmd_i,
  input  wire cildt_trg_t        timer_trigger_select_i,
  input  wire cildt_cond_t       timer_trigger_condition_i,
  // sensor status
  input  wire logic              exposure_start_i,
  input  wire logic              exposure_end_i,
  input  wire logic              readout_status_i,
  // pins
  input  wire logic              input_line_a_i,
  output logic                   output_line_b_o,
  output logic                   output_line_b_oe_n_o,
  // status
  output logic                   io_line_direction_o,
  output logic                   exposure_status_o,
  output logic                   filtered_input_o,
  output logic                   timer_pulse_out_o
);
  import cildt_pkg::*;

  cildt_tick_if tk();

  logic exp_r, exp_nxt;
  logic out_r, out_nxt;
  logic oe_n_r, oe_n_nxt;
  logic dir_r, dir_nxt;
  logic filt_r, filt_nxt;
  logic trg_src;
  logic tmr_pulse;
  logic [FILT_W-1:0] filt_us;

  // values above the range are clamped rather than wrapped
  assign filt_us = (input_filter_time_i > FILT_W'(FILT_MAX_US)) ?
                   FILT_W'(FILT_MAX_US) : input_filter_time_i;

  cildt_filter u_filter
  (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .input_line_a_i (input_line_a_i),
    .filt_us_i      (filt_us),
    .tk             (tk.src)
  );

  // trigger source multiplexer
  always_comb
  begin
    case (timer_trigger_select_i)
      TRG_EXPOSURE: trg_src = exp_r;
      TRG_READOUT:  trg_src = readout_status_i;
      TRG_INPUT:    trg_src = tk.filt_level;
      default:      trg_src = 1'b0;
    endcase
  end

  cildt_timer u_timer
  (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .restart_i  (timer_restart_cmd_i),
    .enable_i   (timer_trigger_select_i != TRG_NONE),
    .cond_i     (timer_trigger_condition_i),
    .delay_us_i (timer_start_delay_i),
    .dur_us_i   (timer_pulse_width_i),
    .src_i      (trg_src),
    .tk         (tk.dst),
    .pulse_o    (tmr_pulse)
  );

  // exposure status, output line mux and direction readback
  always_comb
  begin
    exp_nxt = exp_r;
    // a new start wins over an end in the same cycle
    if (exposure_end_i)
      exp_nxt = 1'b0;
    if (exposure_start_i)
      exp_nxt = 1'b1;
    oe_n_nxt = 1'b0;
    case (output_drive_source_i)
      SRC_EXPOSURE: out_nxt = exp_r;
      SRC_READOUT:  out_nxt = readout_status_i;
      SRC_SOFTWARE: out_nxt = software_bit_value_i;
      SRC_TIMER:    out_nxt = tmr_pulse;
      default:
      begin
        out_nxt  = 1'b0;
        oe_n_nxt = 1'b1;
      end
    endcase
    // inversion only applies while the line is actively driven
    if (output_polarity_invert_i && !oe_n_nxt)
      out_nxt = !out_nxt;
    dir_nxt  = (io_line_select_i == LINE_OUT) ? 1'b1 : 1'b0;
    filt_nxt = tk.filt_level;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      exp_r  <= 1'b0;
      out_r  <= 1'b0;
      oe_n_r <= 1'b1;
      dir_r  <= 1'b0;
      filt_r <= 1'b0;
    end
    else
    begin
      exp_r  <= exp_nxt;
      out_r  <= out_nxt;
      oe_n_r <= oe_n_nxt;
      dir_r  <= dir_nxt;
      filt_r <= filt_nxt;
    end
  end

  assign output_line_b_o      = out_r;
  assign output_line_b_oe_n_o = oe_n_r;
  assign io_line_direction_o  = dir_r;
  assign exposure_status_o    = exp_r;
  assign filtered_input_o     = filt_r;
  assign timer_pulse_out_o    = tmr_pulse;
endmodule

// >>> dv/cildt_ext_model.sv
/*
  external trigger source wired to the camera input pin.
  assumes pulses start just after a rising clock edge.
*/
`timescale 1ns/10ps
module cildt_ext_model
(
  // clock and pin
  input  logic clk_i,
  output logic line_o
);
  // the line rests low until the first pulse
  initial line_o = 1'b0;

  // hold lvl for k cycles, then settle at the other level
  task automatic pulse(input logic lvl, input int k);
    line_o = lvl;
    repeat (k) @(posedge clk_i);
    #2;
    line_o = !lvl;
  endtask
endmodule

// >>> dv/cildt_chk.sv
/*
  port assertions for the camera i/o block.
  assumes one clock and the async low reset.
*/
`timescale 1ns/10ps
module cildt_chk
  import cildt_pkg::*;
(
  // clock, reset and settings
  input logic       ref_clk_i,
  input logic       arst_n_i,
  input logic       io_line_select_i,
  input logic       output_polarity_invert_i,
  input cildt_src_t output_drive_source_i,
  input logic       software_bit_value_i,
  input cildt_trg_t timer_trigger_select_i,
  input logic       exposure_start_i,
  input logic       readout_status_i,
  // outputs
  input logic       output_line_b_o,
  input logic       output_line_b_oe_n_o,
  input logic       io_line_direction_o,
  input logic       exposure_status_o,
  input logic       timer_pulse_out_o
);
  logic up_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // masks the first edge after reset, where $past sees reset values
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      up_r <= 1'b0;
    else
      up_r <= 1'b1;

  chk_dir_follow:
    assert property (up_r |-> io_line_direction_o == $past(io_line_select_i))
      else $error("direction wrong");
  chk_off_undriven:
    assert property (up_r |-> output_line_b_oe_n_o ==
      ($past(output_drive_source_i) == SRC_OFF)) else $error("enable wrong");
  chk_soft_drive:
    assert property (up_r && $past(output_drive_source_i) == SRC_SOFTWARE
      |-> output_line_b_o == ($past(software_bit_value_i) ^
      $past(output_polarity_invert_i))) else $error("soft level wrong");
  chk_read_drive:
    assert property (up_r && $past(output_drive_source_i) == SRC_READOUT
      |-> output_line_b_o == ($past(readout_status_i) ^
      $past(output_polarity_invert_i))) else $error("readout level wrong");
  chk_exp_drive:
    assert property (up_r && $past(output_drive_source_i) == SRC_EXPOSURE
      |-> output_line_b_o == ($past(exposure_status_o) ^
      $past(output_polarity_invert_i))) else $error("exposure level wrong");
  chk_timer_drive:
    assert property (up_r && $past(output_drive_source_i) == SRC_TIMER
      |-> output_line_b_o == ($past(timer_pulse_out_o) ^
      $past(output_polarity_invert_i))) else $error("timer level wrong");
  chk_exp_rise:
    assert property (exposure_start_i |=> exposure_status_o)
      else $error("exposure not raised");
  chk_none_idle:
    assert property ((timer_trigger_select_i == TRG_NONE) [*4] |->
      !timer_pulse_out_o) else $error("timer ran untriggered");
endmodule

bind cildt_top cildt_chk i_chk
(
  .ref_clk_i, .arst_n_i, .io_line_select_i, .output_polarity_invert_i,
  .output_drive_source_i, .software_bit_value_i, .timer_trigger_select_i,
  .exposure_start_i, .readout_status_i, .output_line_b_o,
  .output_line_b_oe_n_o, .io_line_direction_o, .exposure_status_o,
  .timer_pulse_out_o
);

// >>> dv/testbench.sv
/*
  self-checking bench for the camera i/o block.
  assumes 20 MHz; a filter setting of 0 means 10 cycles.
*/
`timescale 1ns/10ps
module testbench;
  import cildt_pkg::*;
  logic              clk, rst_n, sel, inv, sw, rcmd, xs, xe, rd, pin;
  logic              lb, oe_n, dir, xst, fin, tp;
  cildt_src_t        src;
  cildt_trg_t        trg;
  cildt_cond_t       cnd;
  logic [FILT_W-1:0] filt;
  logic [TIME_W-1:0] dly, wid;
  int                errors, compares, n;

  cildt_top i_dut
  (
    .ref_clk_i(clk), .arst_n_i(rst_n), .io_line_select_i(sel),
    .output_polarity_invert_i(inv), .output_drive_source_i(src),
    .software_bit_value_i(sw), .input_filter_time_i(filt),
    .timer_start_delay_i(dly), .timer_pulse_width_i(wid),
    .timer_restart_cmd_i(rcmd), .timer_trigger_select_i(trg),
    .timer_trigger_condition_i(cnd), .exposure_start_i(xs),
    .exposure_end_i(xe), .readout_status_i(rd), .input_line_a_i(pin),
    .output_line_b_o(lb), .output_line_b_oe_n_o(oe_n),
    .io_line_direction_o(dir), .exposure_status_o(xst),
    .filtered_input_o(fin), .timer_pulse_out_o(tp)
  );
  cildt_ext_model i_ext
  (
    .clk_i(clk),
    .line_o(pin)
  );

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic check(input string what, input logic [7:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // off, software, readout and exposure sources under both polarities
  task automatic t_src;
    for (int i = 0; i < 2; i++)
    begin
      inv = i[0];
      sel = !inv;
      src = SRC_OFF;
      cyc(2);
      check("dir", dir, !inv);
      check("oe_n", oe_n, 1'b1);
      src = SRC_SOFTWARE;
      sw = 1'b1;
      cyc(2);
      check("soft", {oe_n, lb}, {1'b0, !inv});
      src = SRC_READOUT;
      rd = 1'b1;
      sw = 1'b0;
      cyc(2);
      check("readout", lb, !inv);
      rd = 1'b0;
      src = SRC_EXPOSURE;
      xs = 1'b1;
      cyc(1);
      xs = 1'b0;
      cyc(3);
      check("exp", {xst, lb}, {1'b1, !inv});
      xe = 1'b1;
      cyc(1);
      xe = 1'b0;
      cyc(2);
      check("exp end", {xst, lb}, {1'b0, inv});
    end
  endtask

  // glitches vanish; a steady level lands only after the filter time
  task automatic t_filt;
    i_ext.pulse(1'b1, 5);
    cyc(20);
    check("glitch hi", fin, 1'b0);
    fork
      i_ext.pulse(1'b1, 40);
      begin
        cyc(9);
        check("early", fin, 1'b0);
        cyc(11);
        check("settled", fin, 1'b1);
      end
    join
    i_ext.pulse(1'b0, 1);
    cyc(30);
    i_ext.pulse(1'b0, 5);
    cyc(20);
    check("glitch lo", fin, 1'b1);
    filt = 20'h00002;
    i_ext.pulse(1'b0, 15);
    cyc(60);
    check("long filt", fin, 1'b1);
    i_ext.pulse(1'b1, 1);
    cyc(80);
    check("long fall", fin, 1'b0);
    filt = '0;
  endtask

  // rising then falling edge start a delayed pulse of fixed width
  task automatic t_edge;
    trg = TRG_READOUT;
    src = SRC_TIMER;
    dly = 26'h0000002;
    wid = 26'h0000003;
    for (int c = 0; c < 2; c++)
    begin
      cnd = cildt_cond_t'(c);
      rd = c[0];
      cyc(4);
      rd = !rd;
      cyc(20);
      check("delay", tp, 1'b0);
      for (n = 0; n < 60 && !tp; n++)
        cyc(1);
      for (n = 0; n < 99 && tp; n++)
        cyc(1);
      check("width", n, 60);
    end
  endtask

  // level gates: exposure high, then filtered input low
  task automatic t_level;
    trg = TRG_EXPOSURE;
    cnd = gate_while_high;
    xs = 1'b1;
    cyc(1);
    xs = 1'b0;
    cyc(10);
    check("gate wait", tp, 1'b0);
    cyc(55);
    check("gate on", tp, 1'b1);
    xe = 1'b1;
    cyc(1);
    xe = 1'b0;
    cyc(4);
    check("gate off", tp, 1'b0);
    i_ext.pulse(1'b0, 1);
    cyc(30);
    trg = TRG_INPUT;
    cnd = gate_while_low;
    i_ext.pulse(1'b1, 1);
    cyc(80);
    check("low gate", tp, 1'b1);
    i_ext.pulse(1'b0, 1);
    cyc(30);
    check("low end", tp, 1'b0);
  endtask

  // restart stops a running pulse; no trigger keeps the timer quiet
  task automatic t_restart;
    trg = TRG_READOUT;
    cnd = trig_on_rise;
    dly = '0;
    wid = 26'h0000005;
    rd = 1'b0;
    cyc(4);
    rd = 1'b1;
    cyc(30);
    check("run", tp, 1'b1);
    rcmd = 1'b1;
    cyc(3);
    check("restart", tp, 1'b0);
    rcmd = 1'b0;
    trg = TRG_NONE;
    rd = 1'b0;
    cyc(4);
    rd = 1'b1;
    cyc(30);
    check("none", tp, 1'b0);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    {sel, inv, sw, rcmd, xs, xe, rd} = '0;
    src = SRC_OFF;
    trg = TRG_NONE;
    cnd = trig_on_rise;
    filt = '0;
    dly = '0;
    wid = 26'h0000001;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    t_src;
    t_filt;
    t_edge;
    t_level;
    t_restart;
    stop_test;
  end

  // the scenarios need about 850 cycles; allow far more
  initial
  begin
    #500_000;
    errors++;
    stop_test;
  end
endmodule
